// File: design/cmi_pkg.sv
/*
 * Constants, register map and mode decode types for the comparator
 * mode and change-interrupt block.
 * Assumes an 8-bit register port with 3-bit index addresses.
 */
package cmi_pkg;

    // ------------------------------------------------------------
    // Register index map
    // ------------------------------------------------------------
    localparam logic [2:0] CONFIG_ADDR = 3'h0; // comparator_config_reg
    localparam logic [2:0] AUX_ADDR = 3'h1; // comparator_aux_reg
    localparam logic [2:0] FLAG_ADDR = 3'h2; // peripheral_flag_reg
    localparam logic [2:0] ENABLE_ADDR = 3'h3; // peripheral_enable_reg
    localparam logic [2:0] IRQ_CTRL_ADDR = 3'h4; // irq_control_reg
    localparam logic [2:0] PORT_ADDR = 3'h5; // Masked port readback

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_RESULT2_BIT = 7;
    localparam int CFG_RESULT1_BIT = 6;
    localparam int CFG_INV2_BIT = 5;
    localparam int CFG_INV1_BIT = 4;
    localparam int CFG_SWITCH_BIT = 3;
    localparam int FLAG1_BIT = 3; // change_flag / change_irq_enable of comparator 1
    localparam int FLAG2_BIT = 4;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_EN_BIT = 6;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [1:0] AUX_RESET = 2'h2; // Gate source select set
    localparam logic [1:0] PHASE_LAST = 2'h3; // Four phases per instruction cycle
    localparam logic [1:0] PHASE_FIRST = 2'h0;

    // ------------------------------------------------------------
    // Pin masks: bit 0/1/2 = cmp1 minus/plus/out, 3/4/5 = cmp2
    // ------------------------------------------------------------
    localparam logic [5:0] PINS_ALL_IN = 6'h1B;
    localparam logic [5:0] PINS_C1_IN = 6'h03;
    localparam logic [5:0] PINS_C1_MINUS = 6'h01;
    localparam logic [5:0] PINS_NONE = 6'h00;
    localparam logic [5:0] PINS_OUT = 6'h24;

    // Decoded pin roles of one mode
    typedef struct packed {
        logic [5:0] analog;
        logic [1:0] out_en;
        logic [1:0] switch_ok;
        logic [1:0] enable;
        logic [1:0] cvref;
    } cmi_mode_s;

endpackage : cmi_pkg

// File: design/cmi_mismatch.sv
/*
 * Change detector for one comparator: read latch, phase latch, xor.
 * Assumes load and sample are one-cycle pulses in the system clock.
 */
`timescale 1ns/1ps
module cmi_mismatch (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic result,
    input wire logic sample,
    input wire logic load,
    output logic mismatch,
    output logic mismatch_rise
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic read_latch;  // Level seen at last config access
        logic phase_latch; // Level seen at last first phase
        logic prev;        // Mismatch one cycle back
    } cmi_mm_s;

    cmi_mm_s st_reg;
    cmi_mm_s st_next;

    assign mismatch = st_reg.read_latch ^ st_reg.phase_latch;
    assign mismatch_rise = mismatch & ~st_reg.prev;

    // Next-state logic
    always_comb
    begin
        st_next = st_reg;
        st_next.prev = mismatch;
        if (sample)
        begin
            st_next.phase_latch = result;
        end
        if (load)
        begin
            st_next.read_latch = sample ? result : st_reg.phase_latch;
        end
    end

    // Register stage
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    read_ends_a: assert property (load |=> !mismatch)
        else $error("config access left a mismatch");
    phase_sample_a: assert property (sample |=> st_reg.phase_latch == $past(result))
        else $error("phase latch missed its sample");
    latch_hold_a: assert property (!load |=> $stable(st_reg.read_latch))
        else $error("read latch moved without access");

endmodule : cmi_mismatch

// File: design/cmi_comparator_ctrl.sv
/*
 * Comparator mode, polarity, input switch and change-interrupt control.
 * Assumes the analog comparators deliver cmp_raw as plus-above-minus
 * levels synchronous to sys_clk, and a plain index register port.
 */
`timescale 1ns/1ps
module cmi_comparator_ctrl #(
    parameter int DUAL = 1 // 1: two comparators, 0: single comparator
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic [1:0] cmp_raw,
    input wire logic [5:0] port_in,
    input wire logic [5:0] port_out,
    input wire logic [5:0] pin_direction,
    output logic [5:0] pin_o,
    output logic [5:0] pin_oe,
    output logic [5:0] analog_mask,
    output logic [1:0] cmp_enable,
    output logic [1:0] inverting_input_select,
    output logic [1:0] cvref_select,
    output logic [1:0] compare_result,
    output logic irq_req,
    output logic wake_req
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DUAL != 0 && DUAL != 1)
    begin : g_bad_dual
        $error("DUAL must be 0 or 1");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] mode_select;      // Mode field
        logic in_switch;              // Input switch bit
        logic [1:0] result_invert;    // Per comparator polarity
        logic [1:0] aux;              // Gate source and sync bits, stored only
        logic [1:0] change_flag;      // Sticky change flags
        logic [1:0] change_irq_enable;
        logic peripheral_irq_enable;
        logic global_irq_enable;
        logic [1:0] result;           // Registered compare results
        logic [1:0] phase;            // Clock phase counter
        logic [7:0] rdata;            // Read data, one cycle after strobe
    } cmi_state_s;

    cmi_state_s st_reg;
    cmi_state_s st_next;
    cmi_pkg::cmi_mode_s md;           // Decoded mode
    logic first_clock_phase;          // One-cycle phase pulse
    logic cfg_access;                 // Config read or write
    logic [1:0] mismatch;
    logic [1:0] mismatch_rise;
    logic [1:0] comp_mask;            // Comparators present
    logic [7:0] cfg_view;             // Config register read image

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic cmi_pkg::cmi_mode_s decode_mode(input logic [2:0] m, input logic dual);
        cmi_pkg::cmi_mode_s d;
        d = '0;
        if (dual)
        begin
            d.analog = cmi_pkg::PINS_ALL_IN;
            d.enable = 2'h3;
            case (m)
                3'h0: d.enable = 2'h0;
                // Three inputs, switch on comparator 1
                3'h1: d.switch_ok = 2'h1;
                // Four inputs, switch on both
                3'h2: d.switch_ok = 2'h3;
                3'h3: d.cvref = 2'h3;
                3'h4: d.cvref = 2'h0;
                // One independent comparator
                3'h5:
                begin
                    d.analog = cmi_pkg::PINS_C1_IN;
                    d.enable = 2'h1;
                end
                // Outputs and common reference
                3'h6:
                begin
                    d.out_en = 2'h3;
                    d.cvref = 2'h3;
                end
                default:
                begin
                    d.analog = cmi_pkg::PINS_NONE;
                    d.enable = 2'h0;
                end
            endcase
        end
        else
        begin
            d.analog = cmi_pkg::PINS_C1_IN;
            d.enable = 2'h1;
            case (m)
                3'h0: d.enable = 2'h0;
                3'h1: d.out_en = 2'h1;
                3'h2: d.out_en = 2'h0;
                3'h3:
                begin
                    d.analog = cmi_pkg::PINS_C1_MINUS;
                    d.out_en = 2'h1;
                    d.cvref = 2'h1;
                end
                3'h4:
                begin
                    d.analog = cmi_pkg::PINS_C1_MINUS;
                    d.cvref = 2'h1;
                end
                3'h5:
                begin
                    d.out_en = 2'h1;
                    d.switch_ok = 2'h1;
                    d.cvref = 2'h1;
                end
                3'h6:
                begin
                    d.switch_ok = 2'h1;
                    d.cvref = 2'h1;
                end
                default:
                begin
                    d.analog = cmi_pkg::PINS_NONE;
                    d.enable = 2'h0;
                end
            endcase
        end
        return d;
    endfunction : decode_mode

    // pin roles and power from the mode field
    assign md = decode_mode(st_reg.mode_select, DUAL == 1);
    assign comp_mask = (DUAL == 1) ? 2'h3 : 2'h1;

    // ------------------------------------------------------------
    // Pins and comparator controls
    // ------------------------------------------------------------
    assign analog_mask = md.analog;
    assign cmp_enable = md.enable;
    assign cvref_select = md.cvref;
    // switch only where the mode allows it
    assign inverting_input_select = md.switch_ok & {2{st_reg.in_switch}};
    assign compare_result = st_reg.result;
    assign pin_oe = ~pin_direction;

    // Output pin muxing
    always_comb
    begin
        pin_o = port_out;
        // result overrides the port on output pins
        if (md.out_en[0])
        begin
            pin_o[2] = st_reg.result[0];
        end
        if (md.out_en[1])
        begin
            pin_o[5] = st_reg.result[1];
        end
    end

    // ------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------
    assign first_clock_phase = (st_reg.phase == cmi_pkg::PHASE_FIRST);
    assign cfg_access = (bus_rd | bus_wr) & (bus_addr == cmi_pkg::CONFIG_ADDR);

    for (genvar i = 0; i < 2; i++)
    begin : g_mm
        cmi_mismatch u_mm (
            .sys_clk(sys_clk),
            .reset(reset),
            .result(st_reg.result[i]),
            .sample(first_clock_phase),
            .load(cfg_access),
            .mismatch(mismatch[i]),
            .mismatch_rise(mismatch_rise[i])
        );
    end

    assign irq_req = (|(st_reg.change_flag & st_reg.change_irq_enable))
        & st_reg.peripheral_irq_enable & st_reg.global_irq_enable;
    assign wake_req = (|(st_reg.change_flag & st_reg.change_irq_enable))
        & st_reg.peripheral_irq_enable;

    // Config register image
    always_comb
    begin
        cfg_view = 8'h00;
        cfg_view[cmi_pkg::CFG_RESULT1_BIT] = st_reg.result[0];
        cfg_view[cmi_pkg::CFG_INV1_BIT] = st_reg.result_invert[0];
        cfg_view[cmi_pkg::CFG_SWITCH_BIT] = st_reg.in_switch;
        cfg_view[2:0] = st_reg.mode_select;
        if (DUAL == 1)
        begin
            cfg_view[cmi_pkg::CFG_RESULT2_BIT] = st_reg.result[1];
            cfg_view[cmi_pkg::CFG_INV2_BIT] = st_reg.result_invert[1];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.phase = (st_reg.phase == cmi_pkg::PHASE_LAST) ? cmi_pkg::PHASE_FIRST
            : st_reg.phase + 2'h1;
        // polarity applied; off comparators read low
        st_next.result = (cmp_raw ^ st_reg.result_invert) & md.enable & comp_mask;
        // Register writes
        if (bus_wr)
        begin
            if (bus_addr == cmi_pkg::CONFIG_ADDR)
            begin
                st_next.mode_select = bus_wdata[2:0];
                st_next.in_switch = bus_wdata[cmi_pkg::CFG_SWITCH_BIT];
                st_next.result_invert[0] = bus_wdata[cmi_pkg::CFG_INV1_BIT];
                st_next.result_invert[1] = bus_wdata[cmi_pkg::CFG_INV2_BIT] & (DUAL == 1);
            end
            else if (bus_addr == cmi_pkg::AUX_ADDR)
            begin
                st_next.aux = bus_wdata[1:0];
            end
            else if (bus_addr == cmi_pkg::FLAG_ADDR)
            begin
                // write zero clears, one simulates a change
                st_next.change_flag[0] = bus_wdata[cmi_pkg::FLAG1_BIT];
                st_next.change_flag[1] = bus_wdata[cmi_pkg::FLAG2_BIT] & (DUAL == 1);
            end
            else if (bus_addr == cmi_pkg::ENABLE_ADDR)
            begin
                st_next.change_irq_enable[0] = bus_wdata[cmi_pkg::FLAG1_BIT];
                st_next.change_irq_enable[1] = bus_wdata[cmi_pkg::FLAG2_BIT] & (DUAL == 1);
            end
            else if (bus_addr == cmi_pkg::IRQ_CTRL_ADDR)
            begin
                st_next.global_irq_enable = bus_wdata[cmi_pkg::GLOBAL_EN_BIT];
                st_next.peripheral_irq_enable = bus_wdata[cmi_pkg::PERIPH_EN_BIT];
            end
        end
        // set on rise, held while mismatch lasts; set wins
        st_next.change_flag = st_next.change_flag | ((mismatch_rise | mismatch) & comp_mask);
        // Register reads
        if (bus_rd)
        begin
            if (bus_addr == cmi_pkg::CONFIG_ADDR)
            begin
                st_next.rdata = cfg_view;
            end
            else if (bus_addr == cmi_pkg::AUX_ADDR)
            begin
                st_next.rdata = {6'h00, st_reg.aux};
            end
            else if (bus_addr == cmi_pkg::FLAG_ADDR)
            begin
                st_next.rdata = {3'h0, st_reg.change_flag, 3'h0};
            end
            else if (bus_addr == cmi_pkg::ENABLE_ADDR)
            begin
                st_next.rdata = {3'h0, st_reg.change_irq_enable, 3'h0};
            end
            else if (bus_addr == cmi_pkg::IRQ_CTRL_ADDR)
            begin
                st_next.rdata = {st_reg.global_irq_enable, st_reg.peripheral_irq_enable, 6'h00};
            end
            else if (bus_addr == cmi_pkg::PORT_ADDR)
            begin
                st_next.rdata = {2'h0, port_in & ~md.analog};
            end
            else
            begin
                // Unmapped index
                st_next.rdata = 8'h00;
            end
        end
    end

    // Register stage
    always_ff @(posedge sys_clk)
    begin
        // back to mode 000, comparator inputs analog, off
        if (reset)
        begin
            st_reg <= '0;
            st_reg.mode_select <= cmi_pkg::MODE_RESET;
            st_reg.aux <= cmi_pkg::AUX_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign bus_rdata = st_reg.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    reset_mode_a: assert property (disable iff (1'b0) reset |=>
        st_reg.mode_select == 3'h0 && cmp_enable == 2'h0 && analog_mask != 6'h00)
        else $error("reset did not restore mode 000");
    analog_zero_a: assert property (bus_rd && bus_addr == cmi_pkg::PORT_ADDR |=>
        (bus_rdata[5:0] & $past(analog_mask)) == 6'h00)
        else $error("analog pin read nonzero");
    pin_override_a: assert property (md.out_en[0] |-> pin_o[2] == compare_result[0])
        else $error("output pin not carrying result");
    pin_modes_a: assert property (md.out_en != 2'h0 |->
        (DUAL == 1) ? st_reg.mode_select == 3'h6 : st_reg.mode_select inside {3'h1, 3'h3, 3'h5})
        else $error("result on pin in wrong mode");
    polarity_a: assert property ($past(cmp_enable[0]) |->
        compare_result[0] == ($past(cmp_raw[0]) ^ $past(st_reg.result_invert[0])))
        else $error("result polarity wrong");
    switch_modes_a: assert property (inverting_input_select[0] |->
        (DUAL == 1) ? st_reg.mode_select inside {3'h1, 3'h2}
        : st_reg.mode_select inside {3'h5, 3'h6})
        else $error("input switch in wrong mode");
    off_modes_a: assert property (st_reg.mode_select inside {3'h0, 3'h7} |->
        cmp_enable == 2'h0 ##1 compare_result == 2'h0)
        else $error("comparator running while off");
    flag_rise_a: assert property (mismatch_rise[0] |=> st_reg.change_flag[0])
        else $error("flag missed mismatch");
    flag_hold_a: assert property (mismatch[0] ##1 mismatch[0] |-> st_reg.change_flag[0])
        else $error("flag cleared during mismatch");
    irq_gate_a: assert property ($rose(irq_req) |->
        st_reg.global_irq_enable && st_reg.peripheral_irq_enable)
        else $error("request without enables");
    flag_write_a: assert property (bus_wr && bus_addr == cmi_pkg::FLAG_ADDR
        && mismatch == 2'h0 && mismatch_rise == 2'h0 |=>
        st_reg.change_flag[0] == $past(bus_wdata[cmi_pkg::FLAG1_BIT]))
        else $error("flag write not taken");

endmodule : cmi_comparator_ctrl

// File: test/tb_comparator_mode_and_change_irq.sv
/*
 * Self-checking bench for the comparator mode and change-interrupt block.
 * Assumes the default dual variant, a 100 MHz clock and the register map
 * of the package.
 */
`timescale 1ns/1ps
module tb_comparator_mode_and_change_irq;
    // ------------------------------------------------------------
    // Stimulus, outputs and counters
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic reset;
    logic [2:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_rdata;
    logic [1:0] cmp_raw;
    logic [5:0] port_in;
    logic [5:0] port_out;
    logic [5:0] pin_direction;
    logic [5:0] pin_o;
    logic [5:0] pin_oe;
    logic [5:0] analog_mask;
    logic [1:0] cmp_enable;
    logic [1:0] inverting_input_select;
    logic [1:0] cvref_select;
    logic [1:0] compare_result;
    logic irq_req;
    logic wake_req;
    logic [7:0] rd_data; // Last read value
    int n_fail = 0;
    int tests_run = 0;
    int seed = 32'hE796; // Fixed seed, repeatable run
    int m;
    int i;

    // Free-running system clock
    always #5 sys_clk = ~sys_clk;

    cmi_comparator_ctrl dut_u (
        .sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cmp_raw(cmp_raw),
        .port_in(port_in), .port_out(port_out), .pin_direction(pin_direction),
        .pin_o(pin_o), .pin_oe(pin_oe), .analog_mask(analog_mask), .cmp_enable(cmp_enable),
        .inverting_input_select(inverting_input_select), .cvref_select(cvref_select),
        .compare_result(compare_result), .irq_req(irq_req), .wake_req(wake_req)
    );

    // ------------------------------------------------------------
    // Bus tasks, checks and expectations
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        #1;
    endtask : wr

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        rd_data = bus_rdata;
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc

    // Fresh random pin and comparator levels
    task automatic rnd_in();
        @(posedge sys_clk);
        port_in <= 6'($random(seed));
        port_out <= 6'($random(seed));
        pin_direction <= 6'($random(seed));
        cmp_raw <= 2'($random(seed));
    endtask : rnd_in

    // Input switch only in modes 010 (both) and 001 (first only)
    function automatic logic [7:0] exp_sw(input int md);
        return (md == 2) ? 8'h03 : ((md == 1) ? 8'h01 : 8'h00);
    endfunction : exp_sw

    // Result drives the output pins only in mode 110
    function automatic logic [7:0] exp_pin(input int md);
        return (md == 6) ? {6'h00, cmp_raw} : {6'h00, port_out[5], port_out[2]};
    endfunction : exp_pin

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // Watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        #100000;
        n_fail++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        bus_addr = 3'h0;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        cmp_raw = 2'h0;
        port_in = 6'h00;
        port_out = 6'h00;
        pin_direction = 6'h3F; // analog pins left as inputs
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        wait_cyc(1);
        rd(cmi_pkg::CONFIG_ADDR);
        chk(rd_data, 8'h00, "config reset");
        rd(cmi_pkg::AUX_ADDR);
        chk(rd_data, 8'h02, "aux reset");
        chk({2'h0, analog_mask}, 8'h1B, "reset mask");
        // Unmapped indices read zero, writes ignored
        wr(3'h7, 8'hFF);
        rd(3'h7);
        chk(rd_data, 8'h00, "unmapped");
        // Every mode, input switch bit set, interrupts still disabled
        for (m = 0; m < 8; m++)
        begin
            wr(cmi_pkg::CONFIG_ADDR, 8'(8 + m));
            rnd_in();
            wait_cyc(3);
            chk(8'(|cmp_enable), 8'(m != 0 && m != 7), "enable");
            chk({6'h0, inverting_input_select}, exp_sw(m), "switch");
            chk({6'h0, pin_o[5], pin_o[2]}, exp_pin(m), "out pin");
            chk({6'h0, cvref_select}, (m == 3 || m == 6) ? 8'h03 : 8'h00, "reference");
            chk({2'h0, pin_oe}, {2'h0, ~pin_direction}, "oe");
            if (m == 1 || m == 2)
                chk({6'h0, analog_mask[1:0]}, 8'h03, "both analog");
            if (m == 0 || m == 7)
            begin
                chk({2'h0, analog_mask}, (m == 0) ? 8'h1B : 8'h00, "mask");
                rd(cmi_pkg::PORT_ADDR);
                chk(rd_data, {2'h0, port_in & ((m == 0) ? 6'h24 : 6'h3F)}, "port");
            end
        end
        // Polarity of both results, result bits written as ones
        for (i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            cmp_raw <= 2'($random(seed));
            wr(cmi_pkg::CONFIG_ADDR, {2'h3, 2'(i), 4'h2});
            wait_cyc(2);
            chk({6'h0, compare_result}, {6'h0, cmp_raw ^ 2'(i)}, "result port");
            rd(cmi_pkg::CONFIG_ADDR);
            chk(rd_data, {cmp_raw ^ 2'(i), 2'(i), 4'h2}, "invert");
        end
        // Change detection on the first comparator
        @(posedge sys_clk);
        cmp_raw <= 2'h0;
        wr(cmi_pkg::CONFIG_ADDR, 8'h02);
        wait_cyc(100);
        rd(cmi_pkg::CONFIG_ADDR);
        wr(cmi_pkg::FLAG_ADDR, 8'h00);
        wr(cmi_pkg::ENABLE_ADDR, 8'h08);
        wr(cmi_pkg::IRQ_CTRL_ADDR, 8'h40);
        rd(cmi_pkg::FLAG_ADDR);
        chk(rd_data, 8'h00, "flag idle");
        @(posedge sys_clk);
        cmp_raw <= 2'h1;
        wait_cyc(8);
        rd(cmi_pkg::FLAG_ADDR);
        chk(rd_data, 8'h08, "flag set");
        chk({6'h0, wake_req, irq_req}, 8'h02, "wake only");
        wr(cmi_pkg::FLAG_ADDR, 8'h00);
        rd(cmi_pkg::FLAG_ADDR);
        chk(rd_data, 8'h08, "flag held");
        wr(cmi_pkg::IRQ_CTRL_ADDR, 8'hC0);
        chk({6'h0, wake_req, irq_req}, 8'h03, "irq all");
        rd(cmi_pkg::CONFIG_ADDR);
        wr(cmi_pkg::FLAG_ADDR, 8'h00);
        rd(cmi_pkg::FLAG_ADDR);
        chk(rd_data, 8'h00, "flag cleared");
        @(posedge sys_clk);
        cmp_raw <= 2'h0;
        wait_cyc(8);
        rd(cmi_pkg::FLAG_ADDR);
        chk(rd_data, 8'h08, "flag on fall");
        wr(cmi_pkg::CONFIG_ADDR, 8'h02);
        wr(cmi_pkg::FLAG_ADDR, 8'h00);
        rd(cmi_pkg::FLAG_ADDR);
        chk(rd_data, 8'h00, "write clears");
        wr(cmi_pkg::FLAG_ADDR, 8'h10);
        rd(cmi_pkg::FLAG_ADDR);
        chk(rd_data, 8'h10, "soft set");
        chk({6'h0, wake_req, irq_req}, 8'h00, "masked");
        // Reset in mid-run
        wr(cmi_pkg::CONFIG_ADDR, 8'h35);
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        wait_cyc(1);
        rd(cmi_pkg::CONFIG_ADDR);
        chk(rd_data, 8'h00, "config rerun");
        rd(cmi_pkg::FLAG_ADDR);
        chk(rd_data, 8'h00, "flag rerun");
        report_and_stop();
    end
endmodule : tb_comparator_mode_and_change_irq
